// file: frs_rate_result.sv
// Purpose: Rate register, density pin and result byte read-out.
// Assumes: Host strobes, address and data come from pins and are
//          held stable around each strobe.
// Notes:   Two-flop pin sync costs about three clocks of strobe
//          latency; host cycles must be longer than that.
module frs_rate_result
  import frs_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [9:0]       hostAddr,
  input  wire logic             hostWrite_n,
  input  wire logic             hostRead_n,
  input  wire logic [7:0]       hostDataIn,
  output logic      [7:0]       hostDataOut,
  output logic                  hostDataOe,
  input  wire logic             identSel,
  input  wire logic             encodingModeBit,
  input  wire logic             dmaEnableBit,
  input  wire logic             softResetOutReg,
  input  wire logic             softResetRateReg,
  input  frs_core_events_t      coreEv,
  input  wire logic             trackZeroPin,
  input  wire logic             indexPulsePin,
  input  wire logic             writeProtectPin,
  input  wire logic             diskChangePin,
  output logic      [1:0]       rateCode,
  output logic                  precompDisableBit,
  output logic                  densitySelectPin,
  output logic                  resultPending
);

  // Pin synchronisers, first stage feeds only the second
  logic [PIN_COUNT-1:0] rawPins, pinMeta, pinSync;
  assign rawPins = {trackZeroPin, indexPulsePin,
                    writeProtectPin, diskChangePin};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pinSync
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          pinMeta[gi] <= 1'b0;
          pinSync[gi] <= 1'b0;
        end else begin
          pinMeta[gi] <= rawPins[gi];
          pinSync[gi] <= pinMeta[gi];
        end
      end
    end
  endgenerate

  frs_disk_pins_t pins;
  assign pins = frs_disk_pins_t'(pinSync);

  // Host bus synchronisers
  logic [9:0] addrMeta, addrSync;
  logic [7:0] dataMeta, dataSync;
  logic [1:0] strbMeta, strbSync;
  logic       wrPrev, rdPrev;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addrMeta <= '0;
      addrSync <= '0;
      dataMeta <= '0;
      dataSync <= '0;
      strbMeta <= '0;
      strbSync <= '0;
      wrPrev   <= 1'b0;
      rdPrev   <= 1'b0;
    end else begin
      addrMeta <= hostAddr;
      addrSync <= addrMeta;
      dataMeta <= hostDataIn;
      dataSync <= dataMeta;
      strbMeta <= {~hostWrite_n, ~hostRead_n};
      strbSync <= strbMeta;
      wrPrev   <= strbSync[1];
      rdPrev   <= strbSync[0];
    end
  end

  logic wrStart, rdStart, rdActive, softReset;
  assign wrStart   = strbSync[1] & ~wrPrev;
  assign rdStart   = strbSync[0] & ~rdPrev;
  assign rdActive  = strbSync[0];
  assign softReset = softResetOutReg | softResetRateReg;

  frs_mode_t mode;
  always_comb begin
    if (identSel)
      mode = FRS_MODE_AT;
    else if (encodingModeBit)
      mode = FRS_MODE_PS2;
    else
      mode = FRS_MODE_M30;
  end

  // Result byte builder
  logic [7:0] statusZero, statusOne;
  logic       resultReady;

  frs_result_status u_status (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .softReset   (softReset),
    .coreEv      (coreEv),
    .pins        (pins),
    .statusZero  (statusZero),
    .statusOne   (statusOne),
    .resultReady (resultReady)
  );

  // Rate register; software resets deliberately do not reach it
  logic [1:0] next_rateCode;
  logic       next_precompDisableBit;
  logic       next_densitySelectPin;
  logic       densHigh;

  assign densHigh = (next_rateCode == RATE_CODE_250K) ||
                    (next_rateCode == RATE_CODE_300K);

  always_comb begin
    next_rateCode          = rateCode;
    next_precompDisableBit = precompDisableBit;
    if (wrStart && addrSync == ADDR_RATE_CONFIG) begin
      next_rateCode = dataSync[RATE_MSB:RATE_LSB];
      // Reserved bits are expected at zero and are ignored here
      if (mode == FRS_MODE_M30)
        next_precompDisableBit = dataSync[PRECOMP_BIT];
    end
    // AT mode drives the pin active high, the others active low
    if (mode == FRS_MODE_AT)
      next_densitySelectPin = densHigh;
    else
      next_densitySelectPin = ~densHigh;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rateCode          <= RATE_RESET;
      precompDisableBit <= 1'b0;
      densitySelectPin  <= DENSITY_RESET;
    end else begin
      rateCode          <= next_rateCode;
      precompDisableBit <= next_precompDisableBit;
      densitySelectPin  <= next_densitySelectPin;
    end
  end

  // Result phase sequencer
  frs_res_state_t resState, next_resState;
  logic [7:0]     next_hostDataOut;

  always_comb begin
    next_resState    = resState;
    next_hostDataOut = hostDataOut;
    if (rdStart && addrSync == ADDR_DATA) begin
      case (resState)
        FRS_RES_BYTE0: begin
          next_hostDataOut = statusZero;
          next_resState    = FRS_RES_BYTE1;
        end
        FRS_RES_BYTE1: begin
          next_hostDataOut = statusOne;
          next_resState    = FRS_RES_IDLE;
        end
        FRS_RES_IDLE: begin
          next_hostDataOut = 8'h00;
        end
        default: begin
          next_resState = FRS_RES_IDLE;
        end
      endcase
    end else if (rdStart && addrSync == ADDR_RATE_CONFIG) begin
      case (mode)
        FRS_MODE_AT:
          next_hostDataOut = {pins.diskChange, 7'h00};
        FRS_MODE_PS2:
          next_hostDataOut = {pins.diskChange, PS2_FILL_ONES,
                              rateCode[RATE_MSB], rateCode[RATE_LSB],
                              ~densitySelectPin};
        FRS_MODE_M30:
          next_hostDataOut = {pins.diskChange, 3'h0, dmaEnableBit,
                              precompDisableBit, rateCode};
        default:
          next_hostDataOut = 8'h00;
      endcase
    end
    if (resultReady)
      next_resState = FRS_RES_BYTE0;
    if (softReset)
      next_resState = FRS_RES_IDLE;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      resState    <= FRS_RES_IDLE;
      hostDataOut <= 8'h00;
    end else begin
      resState    <= next_resState;
      hostDataOut <= next_hostDataOut;
    end
  end

  // Drive the bus only while a read to one of our addresses is live
  assign hostDataOe = rdActive && !rdStart &&
                      (addrSync == ADDR_DATA ||
                       addrSync == ADDR_RATE_CONFIG);
  assign resultPending = (resState != FRS_RES_IDLE);

endmodule

// file: frs_pkg.sv
// Purpose: Shared constants and types for the floppy rate/result block.
// Assumes: One controller clock; host strobes arrive from pins.
// Notes:   Result bytes are built by frs_result_status.
// How it works
// - Rate register at 3F7, resets 10; rate bits read back in PS2 and alternate modes.
// - Alternate mode keeps readable precompensation-disable bit.
// - Software resets leave precompensation bit alone.
// - Density pin high on hardware reset only.
// - Result phase presents status bytes via data.
// - First byte bits 7:6 give termination code.
// - First byte bit 5 marks positioning complete.
// - Bit 4: no track zero, outward seek.
// - Bit 2 head, bits 1:0 drive number.
// - Unused status bits always read zero.
// - Second byte bit 7 end of track.
// - Second byte bit 5 CRC fault.
// - Second byte bit 4 overrun or underrun.
// - Second byte bit 2 sector missing.
// - Second byte bit 1 write blocked.
// - Second byte bit 0 address mark absent.
// - Rate resets to 250 kbps, hardware only.
// - Two config bits choose register mode.
package frs_pkg;

  localparam logic [9:0] ADDR_RATE_CONFIG = 10'h3F7;
  localparam logic [9:0] ADDR_DATA        = 10'h3F5;

  localparam logic [1:0] RATE_RESET       = 2'h2;
  localparam logic [1:0] RATE_CODE_250K   = 2'h2;
  localparam logic [1:0] RATE_CODE_300K   = 2'h1;
  localparam logic       DENSITY_RESET    = 1'h1;

  localparam int RATE_LSB    = 0;
  localparam int RATE_MSB    = 1;
  localparam int PRECOMP_BIT = 2;

  localparam logic [6:0] RECAL_STEP_LIMIT = 7'h50;
  localparam logic [1:0] INDEX_LIMIT      = 2'h2;

  localparam logic [3:0] PS2_FILL_ONES    = 4'hF;
  localparam int         PIN_COUNT        = 4;

  localparam logic [1:0] TERM_NORMAL  = 2'h0;
  localparam logic [1:0] TERM_ABNORM  = 2'h1;
  localparam logic [1:0] TERM_INVALID = 2'h2;
  localparam logic [1:0] TERM_POLLING = 2'h3;

  typedef enum logic [1:0] {
    FRS_MODE_AT  = 2'b00,
    FRS_MODE_PS2 = 2'b01,
    FRS_MODE_M30 = 2'b10
  } frs_mode_t;

  typedef enum logic [1:0] {
    FRS_RES_IDLE  = 2'b00,
    FRS_RES_BYTE0 = 2'b01,
    FRS_RES_BYTE1 = 2'b10
  } frs_res_state_t;

  // Command core events, all on the controller clock
  typedef struct packed {
    logic       cmdStart;
    logic       cmdDone;
    logic [1:0] terminationCode;
    logic       positioningComplete;
    logic       seekBeyondTrackZero;
    logic       head;
    logic [1:0] unitSelect;
    logic       sectorBeyondEnd;
    logic       transferCountEnd;
    logic       readWriteDataCmd;
    logic       crcFault;
    logic       dataLate;
    logic       sectorMissing;
    logic       recalActive;
    logic       stepPulse;
    logic       idSearchActive;
    logic       idMarkFound;
    logic       dataMarkMissing;
    logic       writeCmdActive;
  } frs_core_events_t;

  // Synchronised disk pins
  typedef struct packed {
    logic trackZeroInput;
    logic indexPulseInput;
    logic writeProtect;
    logic diskChange;
  } frs_disk_pins_t;

endpackage

// file: frs_result_status.sv
// Purpose: Collect command events into the two result status bytes.
// Assumes: Pins already synchronised; events on the same clock.
// Notes:   Flags clear at command start; set beats clear.
module frs_result_status
  import frs_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             softReset,
  input  frs_core_events_t      coreEv,
  input  frs_disk_pins_t        pins,
  output logic [7:0]            statusZero,
  output logic [7:0]            statusOne,
  output logic                  resultReady
);

  logic       driveFault, next_driveFault;
  logic       endOfTrack, next_endOfTrack;
  logic       crcFault, next_crcFault;
  logic       dataLate, next_dataLate;
  logic       missing, next_missing;
  logic       writeBlocked, next_writeBlocked;
  logic       idSyncAbsent, next_idSyncAbsent;
  logic       tcSeen, next_tcSeen;
  logic [6:0] stepCount, next_stepCount;
  logic [1:0] indexCount, next_indexCount;
  logic       indexPrev;
  logic [7:0] next_statusZero, next_statusOne;
  logic       next_resultReady;
  logic       indexEdge;

  assign indexEdge = pins.indexPulseInput & ~indexPrev;

  always_comb begin
    next_driveFault   = driveFault;
    next_endOfTrack   = endOfTrack;
    next_crcFault     = crcFault;
    next_dataLate     = dataLate;
    next_missing      = missing;
    next_writeBlocked = writeBlocked;
    next_idSyncAbsent = idSyncAbsent;
    next_tcSeen       = tcSeen;
    next_stepCount    = stepCount;
    next_indexCount   = indexCount;
    next_statusZero   = statusZero;
    next_statusOne    = statusOne;
    next_resultReady  = 1'b0;
    if (coreEv.cmdStart || softReset) begin
      next_driveFault   = 1'b0;
      next_endOfTrack   = 1'b0;
      next_crcFault     = 1'b0;
      next_dataLate     = 1'b0;
      next_missing      = 1'b0;
      next_writeBlocked = 1'b0;
      next_idSyncAbsent = 1'b0;
      next_tcSeen       = 1'b0;
      next_stepCount    = '0;
      next_indexCount   = '0;
    end
    // Recalibrate gives up after the step limit without track zero
    if (coreEv.recalActive && coreEv.stepPulse
        && !pins.trackZeroInput) begin
      if (stepCount == RECAL_STEP_LIMIT - 7'h1)
        next_driveFault = 1'b1;
      else
        next_stepCount = stepCount + 7'h1;
    end
    if (coreEv.seekBeyondTrackZero)
      next_driveFault = 1'b1;
    if (coreEv.idSearchActive && !coreEv.idMarkFound && indexEdge) begin
      if (indexCount == INDEX_LIMIT - 2'h1)
        next_idSyncAbsent = 1'b1;
      else
        next_indexCount = indexCount + 2'h1;
    end
    if (coreEv.idMarkFound)
      next_indexCount = '0;
    if (coreEv.dataMarkMissing)
      next_idSyncAbsent = 1'b1;
    if (coreEv.transferCountEnd)
      next_tcSeen = 1'b1;
    if (coreEv.sectorBeyondEnd)
      next_endOfTrack = 1'b1;
    if (coreEv.crcFault)
      next_crcFault = 1'b1;
    if (coreEv.dataLate)
      next_dataLate = 1'b1;
    if (coreEv.sectorMissing)
      next_missing = 1'b1;
    if (coreEv.writeCmdActive && pins.writeProtect)
      next_writeBlocked = 1'b1;
    if (coreEv.cmdDone && !softReset) begin
      next_resultReady = 1'b1;
      next_statusZero  = {coreEv.terminationCode,
                          coreEv.positioningComplete,
                          next_driveFault,
                          1'b0,
                          coreEv.head,
                          coreEv.unitSelect};
      // A read/write data command ending without terminal count
      // still reports end of track
      next_statusOne   = {next_endOfTrack |
                          (coreEv.readWriteDataCmd & ~next_tcSeen &
                           ~coreEv.transferCountEnd),
                          1'b0,
                          next_crcFault,
                          next_dataLate,
                          1'b0,
                          next_missing,
                          next_writeBlocked,
                          next_idSyncAbsent};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      driveFault   <= 1'b0;
      endOfTrack   <= 1'b0;
      crcFault     <= 1'b0;
      dataLate     <= 1'b0;
      missing      <= 1'b0;
      writeBlocked <= 1'b0;
      idSyncAbsent <= 1'b0;
      tcSeen       <= 1'b0;
      stepCount    <= '0;
      indexCount   <= '0;
      indexPrev    <= 1'b0;
      statusZero   <= 8'h00;
      statusOne    <= 8'h00;
      resultReady  <= 1'b0;
    end else begin
      driveFault   <= next_driveFault;
      endOfTrack   <= next_endOfTrack;
      crcFault     <= next_crcFault;
      dataLate     <= next_dataLate;
      missing      <= next_missing;
      writeBlocked <= next_writeBlocked;
      idSyncAbsent <= next_idSyncAbsent;
      tcSeen       <= next_tcSeen;
      stepCount    <= next_stepCount;
      indexCount   <= next_indexCount;
      indexPrev    <= pins.indexPulseInput;
      statusZero   <= next_statusZero;
      statusOne    <= next_statusOne;
      resultReady  <= next_resultReady;
    end
  end

endmodule

// file: frs_rate_result_chk.sv
// Purpose: Port checks for rate register, density pin and result read-out.
// Assumes: Host strobes held low six cycles, as the host model does.
// Notes:   Read activity is tracked by a saturating idle counter.
module frs_rate_result_chk
  import frs_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             reset_n,
  input wire logic [9:0]       hostAddr,
  input wire logic             hostWrite_n,
  input wire logic             hostRead_n,
  input wire logic [7:0]       hostDataIn,
  input wire logic [7:0]       hostDataOut,
  input wire logic             hostDataOe,
  input wire logic             identSel,
  input wire logic             encodingModeBit,
  input wire logic             softResetOutReg,
  input wire logic             softResetRateReg,
  input wire frs_core_events_t coreEv,
  input wire logic [1:0]       rateCode,
  input wire logic             precompDisableBit,
  input wire logic             densitySelectPin,
  input wire logic             resultPending
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] readIdle;
  logic [2:0] next_readIdle;
  wire        softAny = softResetOutReg | softResetRateReg;

  always_comb begin
    next_readIdle = readIdle;
    if (!hostRead_n)
      next_readIdle = 3'h0;
    else if (readIdle != 3'h7)
      next_readIdle = readIdle + 3'h1;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      readIdle <= 3'h7;
    else
      readIdle <= next_readIdle;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_rateWrite;
    $fell(hostWrite_n) && hostAddr == ADDR_RATE_CONFIG;
  endsequence
  sequence s_done;
    coreEv.cmdDone && !softAny;
  endsequence

  property p_rateSoft;
    softAny |=> $stable(rateCode);
  endproperty
  a_rateSoft: assert property (p_rateSoft)
    else $error("rate code moved on soft reset");
  property p_precompSoft;
    softAny |=> $stable(precompDisableBit);
  endproperty
  a_precompSoft: assert property (p_precompSoft)
    else $error("precomp bit moved on soft reset");
  property p_densSoft;
    softAny |=> $stable(densitySelectPin);
  endproperty
  a_densSoft: assert property (p_densSoft)
    else $error("density pin moved on soft reset");
  property p_rateCause;
    !$stable(rateCode) |-> $past(hostWrite_n) == 1'b0
      && $past(hostAddr) == ADDR_RATE_CONFIG;
  endproperty
  a_rateCause: assert property (p_rateCause)
    else $error("rate code changed without a rate write");
  property p_rateValue;
    s_rateWrite |-> ##5 rateCode == hostDataIn[RATE_MSB:RATE_LSB];
  endproperty
  a_rateValue: assert property (p_rateValue)
    else $error("rate code does not match written data");
  property p_densMap;
    $stable(identSel) && $stable(encodingModeBit) && $past(reset_n)
      |-> densitySelectPin == ((rateCode == RATE_CODE_250K
      || rateCode == RATE_CODE_300K) ~^ identSel);
  endproperty
  a_densMap: assert property (p_densMap)
    else $error("density pin wrong for mode and rate");
  property p_pending;
    s_done |-> ##2 resultPending;
  endproperty
  a_pending: assert property (p_pending)
    else $error("result not pending two cycles after done");
  property p_oeCause;
    hostDataOe |-> readIdle < 3'h5;
  endproperty
  a_oeCause: assert property (p_oeCause)
    else $error("data bus driven without a read");
  property p_pendDrop;
    $fell(resultPending) |-> readIdle < 3'h5 || $past(softAny);
  endproperty
  a_pendDrop: assert property (p_pendDrop)
    else $error("result pending dropped without a read");
  property p_precompCause;
    !$stable(precompDisableBit) |-> !identSel && !encodingModeBit
      && $past(hostWrite_n) == 1'b0;
  endproperty
  a_precompCause: assert property (p_precompCause)
    else $error("precomp bit changed outside alternate-mode write");
endmodule

bind frs_rate_result frs_rate_result_chk u_chk (.*);

// file: frs_host_model.sv
// Purpose: Host processor on the parallel I/O bus for the rate block.
// Assumes: No ready line; the device answers within three clocks.
// Notes:   Address and data settle four cycles before each strobe.
module frs_host_model
  import frs_pkg::*;
(
  input  wire logic       ref_clk,
  output logic      [9:0] hostAddr,
  output logic            hostWrite_n,
  output logic            hostRead_n,
  output logic      [7:0] hostDataIn,
  input  wire logic [7:0] hostDataOut,
  input  wire logic       hostDataOe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    hostAddr = 10'h000;
    hostWrite_n = 1'b1;
    hostRead_n = 1'b1;
    hostDataIn = 8'hA5;
  end

  task automatic busWrite(input logic [9:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    hostAddr = addr;
    hostDataIn = data;
    repeat (4) @(negedge ref_clk);
    hostWrite_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    hostWrite_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    // Released bus must not keep showing the last byte
    hostDataIn = ~data;
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic busRead(input logic [9:0] addr, output logic [7:0] data,
                         output logic oe);
    @(negedge ref_clk);
    hostAddr = addr;
    repeat (4) @(negedge ref_clk);
    hostRead_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    // Sampled off the clock edge, where the read byte has long settled
    data = hostDataOut;
    oe = hostDataOe;
    @(negedge ref_clk);
    hostRead_n = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
endmodule

// file: test_fdc_rate_ctrl_and_result_status.sv
// Purpose: Self-checking bench for rate register and result bytes.
// Assumes: Host model timing; core events driven on falling edges.
// Notes:   Index search edges ride on the recalibrate step loop.
module test_fdc_rate_ctrl_and_result_status
  import frs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end

  logic ref_clk, reset_n, identSel, encodingModeBit, dmaEnableBit;
  logic softResetOutReg, softResetRateReg, trackZeroPin, indexPulsePin;
  logic writeProtectPin, diskChangePin, hostWrite_n, hostRead_n;
  logic hostDataOe, precompDisableBit, densitySelectPin, resultPending;
  logic [9:0] hostAddr;
  logic [7:0] hostDataIn, hostDataOut, rd;
  logic [1:0] rateCode;
  logic       oe;
  frs_core_events_t coreEv;
  int n_fail, compares, cycles;

  frs_rate_result dut (.*);
  frs_host_model host (.*);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic wrCheck(input logic [7:0] d, input logic pc);
    host.busWrite(ADDR_RATE_CONFIG, d);
    `CHK("rate", d[1:0], rateCode)
    `CHK("precomp", pc, precompDisableBit)
    `CHK("density", (d[1:0] == 2'h1 || d[1:0] == 2'h2) ~^ identSel,
         densitySelectPin)
  endtask

  task automatic runCmd(input int i);
    logic [7:0] exp0;
    logic [7:0] exp1;
    exp0 = {2'(i), i[0], i == 1 || i == 2, 1'b0, i[1], 2'(3 - i)};
    exp1 = {i < 2, 1'b0, i == 1, i == 2, 1'b0, i == 3, i == 2,
            i == 1 || i == 3};
    @(negedge ref_clk);
    coreEv = '0;
    coreEv.cmdStart = 1'b1;
    @(negedge ref_clk);
    coreEv.cmdStart = 1'b0;
    coreEv.terminationCode = 2'(i);
    coreEv.positioningComplete = i[0];
    coreEv.head = i[1];
    coreEv.unitSelect = 2'(3 - i);
    coreEv.readWriteDataCmd = i == 1 || i == 2;
    coreEv.writeCmdActive = i == 2;
    coreEv.recalActive = i >= 2;
    coreEv.idSearchActive = i >= 2;
    writeProtectPin = i == 2;
    // Boundary: 80 steps flag the drive, 79 do not
    for (int s = 0; s < (i == 2 ? 80 : (i == 3 ? 79 : 0)); s++) begin
      @(negedge ref_clk);
      coreEv.stepPulse = 1'b1;
      // One index edge must not flag, the second one must
      indexPulsePin = s == 5 || (i == 3 && s == 40);
      @(negedge ref_clk);
      coreEv.stepPulse = 1'b0;
    end
    @(negedge ref_clk);
    {coreEv.crcFault, coreEv.seekBeyondTrackZero, coreEv.dataLate,
     coreEv.transferCountEnd, coreEv.sectorMissing, coreEv.dataMarkMissing,
     coreEv.sectorBeyondEnd} = {i == 1, i == 1, i == 2, i == 2, i == 3,
                                i == 1, i == 0};
    @(negedge ref_clk);
    // Levels stay valid through cmdDone; only the pulses drop
    {coreEv.crcFault, coreEv.seekBeyondTrackZero, coreEv.dataLate,
     coreEv.transferCountEnd, coreEv.sectorMissing, coreEv.dataMarkMissing,
     coreEv.sectorBeyondEnd} = 7'h00;
    coreEv.cmdDone = 1'b1;
    @(negedge ref_clk);
    coreEv.cmdDone = 1'b0;
    for (int w = 0; w < 10 && resultPending !== 1'b1; w++)
      @(negedge ref_clk);
    `CHK("pending", 1'b1, resultPending)
    host.busRead(ADDR_DATA, rd, oe);
    `CHK("oe", 1'b1, oe)
    `CHK("status0", exp0, rd)
    host.busRead(ADDR_DATA, rd, oe);
    `CHK("status1", exp1, rd)
    host.busRead(ADDR_DATA, rd, oe);
    `CHK("idle", 8'h00, rd)
    `CHK("drained", 1'b0, resultPending)
    writeProtectPin = 1'b0;
  endtask

  initial begin
    {reset_n, identSel, encodingModeBit, dmaEnableBit} = 4'h4;
    {softResetOutReg, softResetRateReg, trackZeroPin} = 3'h0;
    {indexPulsePin, writeProtectPin, diskChangePin} = 3'h0;
    coreEv = '0;
    repeat (20) @(negedge ref_clk);
    `CHK("rateRst", RATE_CODE_250K, rateCode)
    `CHK("densRst", DENSITY_RESET, densitySelectPin)
    `CHK("pcRst", 1'b0, precompDisableBit)
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++)
      wrCheck(8'(i), 1'b0);
    host.busWrite(10'h3F2, 8'h02);
    `CHK("ignored", 2'h3, rateCode)
    $display("test rate_at done");
    identSel = 1'b0;
    wrCheck(8'h07, 1'b1);
    host.busRead(ADDR_RATE_CONFIG, rd, oe);
    `CHK("pcRead", 1'b1, rd[PRECOMP_BIT])
    @(negedge ref_clk);
    softResetOutReg = 1'b1;
    repeat (2) @(negedge ref_clk);
    softResetOutReg = 1'b0;
    softResetRateReg = 1'b1;
    repeat (2) @(negedge ref_clk);
    softResetRateReg = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK("rateSoft", 2'h3, rateCode)
    `CHK("pcSoft", 1'b1, precompDisableBit)
    `CHK("densSoft", 1'b1, densitySelectPin)
    wrCheck(8'h02, 1'b0);
    encodingModeBit = 1'b1;
    wrCheck(8'h01, 1'b0);
    // PS2-mode status read: rate high bit, rate low bit, density
    host.busRead(ADDR_RATE_CONFIG, rd, oe);
    `CHK("stdRead", 8'h7B, rd)
    // Mid-run hardware reset brings rate and density pin back
    @(negedge ref_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK("rateRst2", RATE_RESET, rateCode)
    `CHK("densRst2", DENSITY_RESET, densitySelectPin)
    reset_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    $display("test rate_alt done");
    identSel = 1'b1;
    for (int i = 0; i < 4; i++)
      runCmd(i);
    $display("test result done");
    print_verdict();
  end
endmodule
